// ### core/pst_pkg.sv
/*
  Shared constants for the power-on self-test gating block: register
  offsets, field positions, reset values and widths.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package pst_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] PST_DIG_OFS  = 8'h00;
  localparam logic [7:0] PST_ANA_OFS  = 8'h04;
  localparam logic [7:0] PST_CTRL_OFS = 8'h08;
  localparam logic [7:0] PST_STAT_OFS = 8'h0c;

  // Digital disable register fields.
  localparam int PST_DIG_MASTER_BIT = 0;
  localparam int PST_DIG_LBIST_BIT  = 1;
  localparam int PST_DIG_LOL_BIT    = 2;
  localparam int PST_DIG_LOS0_BIT   = 3;
  localparam int PST_DIG_LOS1_BIT   = 4;
  localparam int PST_DIG_WARN_BIT   = 5;
  localparam int PST_DIG_ERR_BIT    = 6;
  localparam int PST_DIG_FIRST_TEST = 2;
  localparam int PST_DIG_TESTS      = 22;
  localparam int PST_DIG_WIDTH      = 24;
  localparam logic [31:0] PST_DIG_RESET = 32'h0000_0002;

  // Analog disable register fields.
  localparam int PST_ANA_MASTER_BIT = 0;
  localparam int PST_ANA_FIRST_TEST = 1;
  localparam int PST_ANA_TESTS      = 18;
  localparam int PST_ANA_OSC_EXCL   = 19;
  localparam int PST_ANA_BIAS_EXCL  = 20;
  localparam int PST_ANA_WIDTH      = 21;
  localparam logic [31:0] PST_ANA_RESET = 32'h0000_0000;

  // Control and status fields.
  localparam int PST_CTRL_TRIG_BIT  = 0;
  localparam int PST_STAT_BUSY_BIT  = 0;
  localparam int PST_STAT_DONE_BIT  = 1;
  localparam int PST_STAT_DPASS_BIT = 2;
  localparam int PST_STAT_APASS_BIT = 3;

endpackage

// ### core/pst_gate.sv
/*
  Per-test run gating: a test may run only when its own disable bit and
  the master disable of its group are both clear.
  Assumes the caller registers the result before it leaves the block.
*/
`timescale 1ns/10ps
module pst_gate #(
  parameter int W = 8
) (
  // Disable controls
  input  wire logic [W-1:0] dis_i,
  input  wire logic         master_i,
  // Run enables
  output logic      [W-1:0] run_o
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    assign run_o[i] = ~dis_i[i] & ~master_i;
  end

endmodule

// ### core/pst_top.sv
/*
  Power-on self-test gating: two disable registers, a trigger, run
  enables to the test engines and combined pass/fail status.
  Assumes a classic Wishbone master and test engines that answer a start
  pulse with one done pulse carrying per-test fail flags.
*/
// The Wishbone register port and the register offsets are this design's own decisions.
// Overview of operation
// - Digital bit 6 set skips the crystal deviation error test.
// - Digital bit 5 set skips the crystal deviation warning test.
// - Digital bit 4 set skips second crystal signal loss test.
// - Digital bit 3 set skips first crystal signal loss test.
// - Digital bit 2 set skips the PLL lock loss test.
// - Digital bit 1, reset to one, blocks logic self-test at startup.
// - Digital bit 0 set suppresses all digital tests on a trigger.
// - Analog bit 20 set drops bias calibration from analog status.
// - Analog bit 19 set drops oscillator calibration from analog status.
// - Analog bit 18 set skips the regulator low fault check.
// - Analog bit 17 set skips the regulator in-range check.
// - Analog bit 16 set skips the regulator high fault check.
// - Analog bits 15 and 14 skip second and first reference regulators.
// - Analog bits 13 to 11 skip pump, detector, oscillator regulators.
// - Analog bits 10 to 4 each skip one output divider regulator.
// - Analog bits 3 to 1 skip fractional, PLL divider, core regulators.
// - Analog bit 0 set suppresses all analog regulator tests.
// - Digital bits 23 to 7 skip the remaining monitor tests.
`timescale 1ns/10ps
module pst_top
  import pst_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [AW-1:0]            wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Self-test trigger and engine handshake
  input  wire logic                     selftest_trig_i,
  input  wire logic                     test_done_i,
  input  wire logic [PST_DIG_TESTS-1:0] dig_fail_i,
  input  wire logic [PST_ANA_TESTS-1:0] ana_fail_i,
  input  wire logic                     bias_cal_fail_i,
  input  wire logic                     osc_cal_fail_i,
  output logic                          test_start_o,
  output logic      [PST_DIG_TESTS-1:0] dig_run_o,
  output logic      [PST_ANA_TESTS-1:0] ana_run_o,
  output logic                          lbist_startup_en_o
);

  typedef enum logic {PST_IDLE, PST_RUN} pst_state_e;

  typedef struct packed {
    pst_state_e                 st;
    logic [PST_DIG_WIDTH-1:0]   dig;
    logic [PST_ANA_WIDTH-1:0]   ana;
    logic                       ack;
    logic [31:0]                dat;
    logic                       start;
    logic [PST_DIG_TESTS-1:0]   dig_run;
    logic [PST_ANA_TESTS-1:0]   ana_run;
    logic                       lbist_en;
    logic                       done;
    logic                       dig_pass;
    logic                       ana_pass;
  } pst_state_s;

  pst_state_s q;
  pst_state_s d;

  logic [PST_DIG_TESTS-1:0] dig_gate;
  logic [PST_ANA_TESTS-1:0] ana_gate;
  logic [31:0]              bmask;
  logic                     req;
  logic                     wr;
  logic                     trig;

  // skip single digital tests; overrides them all.
  pst_gate #(
    .W (PST_DIG_TESTS)
  ) u_dig_gate (
    .dis_i    (q.dig[PST_DIG_WIDTH-1:PST_DIG_FIRST_TEST]),
    .master_i (q.dig[PST_DIG_MASTER_BIT]),
    .run_o    (dig_gate)
  );

  // skip single regulator tests; overrides them all.
  pst_gate #(
    .W (PST_ANA_TESTS)
  ) u_ana_gate (
    .dis_i    (q.ana[PST_ANA_TESTS:PST_ANA_FIRST_TEST]),
    .master_i (q.ana[PST_ANA_MASTER_BIT]),
    .run_o    (ana_gate)
  );

  for (genvar b = 0; b < 4; b++) begin : g_sel
    assign bmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  // Writes land on the edge that also sees ack high, as the master expects.
  assign req  = wb_cyc_i & wb_stb_i;
  assign wr   = req & wb_we_i & q.ack;
  assign trig = selftest_trig_i
              | (wr && wb_adr_i == PST_CTRL_OFS[AW-1:0]
                 && wb_sel_i[0] && wb_dat_i[PST_CTRL_TRIG_BIT]);

  always_comb begin
    d       = q;
    d.ack   = req & ~q.ack;
    d.start = 1'b0;

    // Reserved bits fall outside the stored width, so they read zero.
    if (wr && wb_adr_i == PST_DIG_OFS[AW-1:0]) begin
      d.dig = PST_DIG_WIDTH'((wb_dat_i & bmask)
            | ({8'h00, q.dig} & ~bmask));
    end else if (wr && wb_adr_i == PST_ANA_OFS[AW-1:0]) begin
      d.ana = PST_ANA_WIDTH'((wb_dat_i & bmask)
            | ({11'h000, q.ana} & ~bmask));
    end

    // The startup logic test follows the stored disable bit directly.
    d.lbist_en = ~d.dig[PST_DIG_LBIST_BIT];

    case (q.st)
      PST_IDLE: begin
        if (trig) begin
          // Run enables are frozen so that a mid-test write cannot alter
          // which per-test fail flags are judged.
          d.st      = PST_RUN;
          d.start   = 1'b1;
          d.dig_run = dig_gate;
          d.ana_run = ana_gate;
        end
      end
      PST_RUN: begin
        if (test_done_i) begin
          d.st       = PST_IDLE;
          d.dig_run  = '0;
          d.ana_run  = '0;
          d.dig_pass = ~|(dig_fail_i & q.dig_run);
          d.ana_pass = ~|(ana_fail_i & q.ana_run)
            & ~(bias_cal_fail_i & ~q.ana[PST_ANA_BIAS_EXCL])
            & ~(osc_cal_fail_i & ~q.ana[PST_ANA_OSC_EXCL]);
        end
      end
      default: d.st = PST_IDLE;
    endcase

    // Done is cleared by writing one; a completion in the same cycle wins.
    if (wr && wb_adr_i == PST_STAT_OFS[AW-1:0] && wb_sel_i[0]
        && wb_dat_i[PST_STAT_DONE_BIT]) begin
      d.done = 1'b0;
    end
    if (q.st == PST_RUN && test_done_i) begin
      d.done = 1'b1;
    end

    // Read data; unmapped addresses answer with ack and zero data.
    d.dat = 32'h0000_0000;
    if (req && !wb_we_i && !q.ack) begin
      if (wb_adr_i == PST_DIG_OFS[AW-1:0]) begin
        d.dat = {8'h00, q.dig};
      end else if (wb_adr_i == PST_ANA_OFS[AW-1:0]) begin
        d.dat = {11'h000, q.ana};
      end else if (wb_adr_i == PST_STAT_OFS[AW-1:0]) begin
        d.dat[PST_STAT_BUSY_BIT]  = (q.st == PST_RUN);
        d.dat[PST_STAT_DONE_BIT]  = q.done;
        d.dat[PST_STAT_DPASS_BIT] = q.dig_pass;
        d.dat[PST_STAT_APASS_BIT] = q.ana_pass;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.st       <= PST_IDLE;
      q.dig      <= PST_DIG_RESET[PST_DIG_WIDTH-1:0];
      q.ana      <= PST_ANA_RESET[PST_ANA_WIDTH-1:0];
      q.lbist_en <= ~PST_DIG_RESET[PST_DIG_LBIST_BIT];
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o           = q.dat;
  assign wb_ack_o           = q.ack;
  assign test_start_o       = q.start;
  assign dig_run_o          = q.dig_run;
  assign ana_run_o          = q.ana_run;
  assign lbist_startup_en_o = q.lbist_en;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence launch_s;
    q.st == PST_IDLE && trig;
  endsequence

  sequence finish_s;
    q.st == PST_RUN && test_done_i;
  endsequence

  bus_answer_a:
    assert property (req && !q.ack |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus request not answered in one cycle.");

  dig_reserved_a:
    assert property (wb_ack_o && !wb_we_i && $past(wb_adr_i) == PST_DIG_OFS
                     |-> wb_dat_o[31:24] == 8'h00)
    else $error("Reserved digital bits read non-zero.");

  err_skip_a:
    assert property (launch_s ##0 q.dig[PST_DIG_ERR_BIT]
                     |=> test_start_o && !dig_run_o[4])
    else $error("Deviation error test ran while disabled.");

  los_skip_a:
    assert property (launch_s ##0 q.dig[PST_DIG_LOS1_BIT]
                     |=> test_start_o && !dig_run_o[2])
    else $error("Signal loss test ran while disabled.");

  dig_master_a:
    assert property (launch_s ##0 q.dig[PST_DIG_MASTER_BIT]
                     |=> test_start_o && dig_run_o == '0
                     ##1 dig_run_o == '0)
    else $error("Digital tests ran under the master disable.");

  ana_master_a:
    assert property (launch_s ##0 q.ana[PST_ANA_MASTER_BIT]
                     |=> ana_run_o == '0)
    else $error("Analog tests ran under the master disable.");

  ana_enable_a:
    assert property (launch_s ##0 q.ana == '0
                     |=> &ana_run_o && test_start_o)
    else $error("Enabled analog tests did not run.");

  bias_count_a:
    assert property (finish_s ##0 bias_cal_fail_i
                     && !q.ana[PST_ANA_BIAS_EXCL]
                     |=> !q.ana_pass && q.done)
    else $error("Included bias failure not reported.");

  osc_drop_a:
    assert property (finish_s ##0 osc_cal_fail_i && !bias_cal_fail_i
                     && q.ana[PST_ANA_OSC_EXCL]
                     && !(|(ana_fail_i & q.ana_run))
                     |=> q.ana_pass)
    else $error("Excluded oscillator failure still counted.");

  lbist_follow_a:
    assert property (lbist_startup_en_o == !q.dig[PST_DIG_LBIST_BIT])
    else $error("Startup logic test enable disagrees with its bit.");

  warn_skip_a:
    assert property (launch_s ##0 q.dig[PST_DIG_WARN_BIT]
                     |=> test_start_o && !dig_run_o[3])
    else $error("Deviation warning test ran while disabled.");

  los0_skip_a:
    assert property (launch_s ##0 q.dig[PST_DIG_LOS0_BIT]
                     |=> test_start_o && !dig_run_o[1])
    else $error("First crystal signal loss test ran while disabled.");

  lol_skip_a:
    assert property (launch_s ##0 q.dig[PST_DIG_LOL_BIT]
                     |=> test_start_o && !dig_run_o[0])
    else $error("Lock loss test ran while disabled.");

  monitor_skip_a:
    assert property (launch_s
                     |=> (dig_run_o[21:5] & $past(q.dig[23:7])) == '0)
    else $error("Monitor test ran while disabled.");

  low_skip_a:
    assert property (launch_s ##0 q.ana[18]
                     |=> test_start_o && !ana_run_o[17])
    else $error("Regulator low fault check ran while disabled.");

  range_skip_a:
    assert property (launch_s ##0 q.ana[17]
                     |=> test_start_o && !ana_run_o[16])
    else $error("Regulator in-range check ran while disabled.");

  high_skip_a:
    assert property (launch_s ##0 q.ana[16]
                     |=> test_start_o && !ana_run_o[15])
    else $error("Regulator high fault check ran while disabled.");

  ref_skip_a:
    assert property (launch_s
                     |=> (ana_run_o[14:13] & $past(q.ana[15:14])) == '0)
    else $error("Reference regulator test ran while disabled.");

  pll_reg_skip_a:
    assert property (launch_s
                     |=> (ana_run_o[12:10] & $past(q.ana[13:11])) == '0)
    else $error("PLL regulator test ran while disabled.");

  div_skip_a:
    assert property (launch_s
                     |=> (ana_run_o[9:3] & $past(q.ana[10:4])) == '0)
    else $error("Output divider regulator test ran while disabled.");

  core_skip_a:
    assert property (launch_s
                     |=> (ana_run_o[2:0] & $past(q.ana[3:1])) == '0)
    else $error("Divider or core regulator test ran while disabled.");

  // A run in progress that the engines have not yet reported done.
  sequence busy_s;
    q.st == PST_RUN && !test_done_i;
  endsequence

  run_hold_a:
    assert property (busy_s |=> $stable(dig_run_o) && $stable(ana_run_o))
    else $error("Run enables changed during a run.");

  busy_trig_a:
    assert property (busy_s ##0 trig |=> !test_start_o)
    else $error("Trigger accepted while a run was busy.");

  run_end_a:
    assert property (finish_s
                     |=> dig_run_o == '0 && ana_run_o == '0 && q.done)
    else $error("Run enables not cleared at the end of a run.");

  dig_fail_a:
    assert property (finish_s ##0 (dig_fail_i & dig_run_o) != '0
                     |=> !q.dig_pass)
    else $error("Failed digital test not reported.");

endmodule

// ### sim/pst_top_test.sv
/*
  Self-checking bench for the self-test gating block, driven over
  classic Wishbone and the trigger and engine-done pins.
  Assumes the block acks each request one cycle after taking it.
*/
`timescale 1ns/10ps
module pst_top_test import pst_pkg::*;;
  logic        clk_i = 0, rst_i = 1;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic        wb_ack_o, test_start_o, lbist_startup_en_o;
  logic        selftest_trig_i = 0, test_done_i = 0;
  logic        bias_cal_fail_i = 0, osc_cal_fail_i = 0;
  logic [21:0] dig_fail_i = 0, dig_run_o;
  logic [17:0] ana_fail_i = 0, ana_run_o;
  int          n_errors = 0, cmp_count = 0;

  pst_top pst_top_i (.*);

  always #10 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // The master holds the request until it samples ack at an edge.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask

  task automatic run(input logic [31:0] dg, an, input logic [21:0] df,
                     input logic [17:0] af, input logic bf, of, hw);
    logic [21:0] er;
    logic [17:0] ea;
    logic        pd, pa;
    int          k;
    er = dg[0] ? '0 : ~dg[23:2];
    ea = an[0] ? '0 : ~an[18:1];
    pd = ~|(df & er);
    pa = ~|(af & ea) & (an[20] | ~bf) & (an[19] | ~of);
    k = 0;
    wr(PST_DIG_OFS, dg);
    wr(PST_ANA_OFS, an);
    wr(PST_STAT_OFS, 32'h2);
    if (hw) begin
      @(posedge clk_i); selftest_trig_i <= 1;
      @(posedge clk_i); selftest_trig_i <= 0;
    end else wr(PST_CTRL_OFS, 32'h1);
    while (test_start_o !== 1'b1 && k < 20) begin @(negedge clk_i); k++; end
    chk(test_start_o, 1, "start");
    chk(dig_run_o, er, "digital run");
    chk(ana_run_o, ea, "analog run");
    @(posedge clk_i);
    test_done_i <= 1; dig_fail_i <= df; ana_fail_i <= af;
    bias_cal_fail_i <= bf; osc_cal_fail_i <= of;
    @(posedge clk_i); test_done_i <= 0;
    rd(PST_STAT_OFS, q);
    chk(q & 32'hf, {28'h0, pa, pd, 2'b10}, "status");
    chk(dig_run_o, 0, "idle run");
  endtask

  task automatic print_verdict;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // About 830 cycles of tests; the limit leaves a wide margin.
  initial begin
    #200000;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd(PST_DIG_OFS, q); chk(q, PST_DIG_RESET, "dig reset");
    rd(PST_ANA_OFS, q); chk(q, PST_ANA_RESET, "ana reset");
    chk(lbist_startup_en_o, 0, "lbist reset");
    // Software that clears this disable also owns the stored signature.
    wr(PST_DIG_OFS, 32'h0);
    repeat (2) @(negedge clk_i);
    chk(lbist_startup_en_o, 1, "lbist on");
    $display("test reset finished");
    wr(PST_DIG_OFS, '1); rd(PST_DIG_OFS, q);
    chk(q, 32'h00ff_ffff, "dig reserved");
    wr(PST_ANA_OFS, '1); rd(PST_ANA_OFS, q);
    chk(q, 32'h001f_ffff, "ana reserved");
    rd(8'h10, q); chk(q, 32'h0, "unmapped");
    $display("test reserved finished");
    // A fail flag only on the skipped test must not spoil the pass bit.
    for (int b = 2; b < 24; b++)
      run(32'h1 << b, 0, 22'h1 << (b - 2), 0, 0, 0, b[0]);
    for (int b = 1; b < 19; b++)
      run(0, 32'h1 << b, 0, 18'h1 << (b - 1), 0, 0, b[0]);
    $display("test per-bit finished");
    run(32'h1, 0, '1, 0, 0, 0, 1);
    run(0, 32'h1, 0, '1, 0, 0, 0);
    $display("test master finished");
    run(0, 0, 22'h1, 18'h1, 0, 0, 1);
    run(0, 0, 0, 0, 1, 0, 1);
    run(0, 32'h0010_0000, 0, 0, 1, 0, 1);
    run(0, 0, 0, 0, 0, 1, 0);
    run(0, 32'h0008_0000, 0, 0, 0, 1, 0);
    $display("test results finished");
    wr(PST_STAT_OFS, 32'h2); rd(PST_STAT_OFS, q);
    chk(q, 32'hc, "done clear");
    // A trigger while busy is ignored, and reset aborts the run.
    wr(PST_CTRL_OFS, 32'h1);
    selftest_trig_i <= 1;
    @(posedge clk_i) selftest_trig_i <= 0;
    @(negedge clk_i) chk(test_start_o, 0, "busy trigger");
    @(posedge clk_i) rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    chk(ana_run_o, 0, "run reset");
    rd(PST_STAT_OFS, q); chk(q, 0, "status reset");
    rd(PST_DIG_OFS, q); chk(q, PST_DIG_RESET, "dig reset again");
    $display("test busy and reset finished");
    print_verdict();
  end
endmodule
